// [logic/iotlb_pkg.sv]
// package for the io tlb index and miss fetch block
package iotlb_pkg;
    localparam int unsigned VPN_W = 20;
    localparam int unsigned IDX_W = 8;
    localparam int unsigned TAG_W = 12;
    localparam int unsigned ENT_W = 64;
    localparam int unsigned DEPTH = 256;
    localparam int unsigned DIR_W = 40;
    localparam int unsigned VIDX_W = 10;
    localparam int unsigned VIDX_LSB = 13;
    localparam int unsigned TAG_LSB = 0;
    localparam int unsigned VALID_BIT = 0;
    localparam int unsigned TAG_EBIT = 1;
    // register offsets
    localparam logic [3:0] OFS_MASK = 4'h0;
    localparam logic [3:0] OFS_BASE_HI = 4'h1;
    localparam logic [3:0] OFS_BASE_LO = 4'h2;
    localparam logic [3:0] OFS_MODE = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_ELO = 4'h5;
    localparam logic [3:0] OFS_EHI = 4'h6;
    localparam logic [3:0] OFS_CMD = 4'h7;
    localparam logic [31:0] MASK_RST = 32'h00000000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [3:0] IOSPACE_TOP = 4'hF;
    typedef enum logic [1:0] {
        IOTLB_REAL = 2'h0, IOTLB_NORMAL = 2'h1, IOTLB_ERROR = 2'h2
    } iotlb_mode_t;
    typedef enum {ST_IDLE, ST_LOOK, ST_FETCH, ST_DONE} iotlb_st_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } iotlb_req_t;
    typedef struct packed {
        logic done;
        logic hard_err;
        logic bypass;
        logic [ENT_W-1:0] entry;
    } iotlb_rsp_t;
    typedef struct packed {
        logic req;
        logic [DIR_W-1:0] addr;
        logic [VIDX_W-1:0] vidx;
        logic coherent;
    } iotlb_mrd_t;
endpackage : iotlb_pkg

// [logic/iotlb_top.sv]
// io tlb index extraction, lookup and page directory miss fetch
`timescale 1ns/10ps
// Function
// R1: index is eight bits extracted by mask from vpn or command page.
// R2: three eight-bit and arrays gated by mask, merged by one or array.
// R3: mask shifted right brings new bits in at index msb side.
// R4: same index for equal vpn and command page value.
// R5: addresses F0xx_xxxx and above bypass translation.
// R6: mask FF00_0000 makes the top byte the entry number.
// R7: mask 7F80_0000 maps 008x to entry 80 and 7F8x to FF.
// R8: software writes the mask before any tlb command or access.
// R9: software programs exactly eight consecutive mask bits.
// R10: software keeps no address bits above the top mask bit.
// R11: mask changes only when idle, then ram re-initialised.
// R12: in auto-fill mode a miss fetches the entry from memory.
// R13: directory address is base plus zero-extended vpn.
// R14: ten directory address bits sent as virtual index.
// R15: directory read is issued coherent.
// R16: returned wanted entry written to ram, then stalled access proceeds; the code writes neither fill nor command when both fall in one cycle.
// R17: software purges or reloads entries after directory changes.
// R18: directory lives in resident, equivalently mapped memory.
// R19: tag always taken from address bits 8 to 19 msb-first; the code takes address bits 23 to 12 (vpn bits 11..0).
// R20: fetched entry without valid bit gives a hard error.
// R21: software-fill mode miss gives a hard error.
// R22: wanted entry chosen by the two low vpn bits.
module iotlb_top
    import iotlb_pkg::*;
(
    input wire logic mclk, // 40 MHz clock
    input wire logic nrst, // sync reset, active low
    input wire logic [3:0] reg_addr, // register word index
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    input wire iotlb_req_t req, // translation request pulse
    output iotlb_rsp_t rsp, // translation answer
    output iotlb_mrd_t mrd, // directory read to memory
    input wire logic mrd_ack, // directory data valid pulse
    input wire logic [4*ENT_W-1:0] mrd_data // four directory entries
);
    typedef struct packed {
        logic [31:0] mask;
        logic [DIR_W-1:0] base;
        logic [1:0] mode;
        logic [ENT_W-1:0] ent;
        logic [31:0] rdata;
        iotlb_st_t st;
        logic [VPN_W-1:0] vpn;
        iotlb_rsp_t rsp;
        iotlb_mrd_t mrd;
        logic err_seen;
    } iotlb_state_t;

    iotlb_state_t s_q, s_d;
    logic [ENT_W-1:0] ram [DEPTH];
    logic [IDX_W-1:0] look_idx, cmd_idx, ram_widx, req_idx;
    logic [ENT_W-1:0] ram_wdata, ram_rd_q;
    logic ram_we;
    logic [DIR_W-1:0] dir_addr;
    logic [ENT_W-1:0] fetched;
    logic [TAG_W-1:0] tag_of_vpn;

    ////////////////////////////////////////////////////////////////////
    // index extractors, one for lookups and one for commands
    iotlb_extract u_ext_look (
        .mask(s_q.mask[31:12]),
        .vpn(s_q.vpn),
        .idx(look_idx)
    );
    iotlb_extract u_ext_cmd (
        .mask(s_q.mask[31:12]),
        .vpn(reg_wdata[31:12]),
        .idx(cmd_idx)
    );
    // ram read is launched from the raw request, so the compare step sees
    // this lookup's entry and not the one of the page number held before
    iotlb_extract u_ext_req (
        .mask(s_q.mask[31:12]),
        .vpn(req.addr[31:12]),
        .idx(req_idx)
    );

    ////////////////////////////////////////////////////////////////////
    // directory address and tag field
    assign dir_addr = s_q.base + {{(DIR_W-VPN_W){1'b0}}, s_q.vpn}; // R13
    assign tag_of_vpn = s_q.vpn[TAG_W-1:0]; // R19
    assign fetched = mrd_data[s_q.vpn[1:0]*ENT_W +: ENT_W]; // R22

    ////////////////////////////////////////////////////////////////////
    // translation ram, single write port shared by fill and command
    // no reset on the array: software writes every entry before use
    always_ff @(posedge mclk) begin
        if (ram_we) begin
            ram[ram_widx] <= ram_wdata;
        end
        ram_rd_q <= ram[req_idx]; // R1
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_d = s_q;
        ram_we = 1'b0;
        ram_widx = cmd_idx; // R4
        ram_wdata = s_q.ent;
        s_d.rsp.done = 1'b0;
        s_d.mrd.req = 1'b0;
        s_d.rdata = 32'h00000000;
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_MASK: s_d.mask = reg_wdata;
                OFS_BASE_HI: s_d.base[DIR_W-1:32] = reg_wdata[DIR_W-33:0];
                OFS_BASE_LO: s_d.base[31:0] = reg_wdata;
                OFS_MODE: s_d.mode = reg_wdata[1:0];
                OFS_STATUS: s_d.err_seen = 1'b0;
                OFS_ELO: s_d.ent[31:0] = reg_wdata;
                OFS_EHI: s_d.ent[63:32] = reg_wdata;
                OFS_CMD: ram_we = 1'b1; // R1
                default: ;
            endcase
        end
        // register reads, unmapped read as zero
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_MASK: s_d.rdata = s_q.mask;
                OFS_BASE_HI: s_d.rdata = {24'h000000, s_q.base[DIR_W-1:32]};
                OFS_BASE_LO: s_d.rdata = s_q.base[31:0];
                OFS_MODE: s_d.rdata = {30'h00000000, s_q.mode};
                OFS_STATUS: s_d.rdata = {28'h0000000, s_q.err_seen,
                    s_q.st == ST_FETCH, s_q.st != ST_IDLE, 1'b0};
                OFS_ELO: s_d.rdata = s_q.ent[31:0];
                OFS_EHI: s_d.rdata = s_q.ent[63:32];
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        // lookup sequencer
        unique case (s_q.st)
            ST_IDLE: begin
                if (req.valid) begin
                    s_d.vpn = req.addr[31:12];
                    s_d.rsp.hard_err = 1'b0;
                    s_d.rsp.bypass = 1'b0;
                    if (req.addr[31:28] == IOSPACE_TOP
                        || s_q.mode == IOTLB_REAL) begin // R5
                        s_d.rsp.bypass = 1'b1;
                        s_d.rsp.done = 1'b1;
                    end else begin
                        s_d.st = ST_LOOK;
                    end
                end
            end
            ST_LOOK: begin
                // tag stored in entry bits 12..1, valid in bit 0
                if (ram_rd_q[VALID_BIT]
                    && ram_rd_q[TAG_W:TAG_EBIT] == tag_of_vpn) begin // R19
                    s_d.rsp.entry = ram_rd_q;
                    s_d.rsp.done = 1'b1;
                    s_d.st = ST_IDLE;
                end else if (s_q.mode == IOTLB_NORMAL) begin
                    s_d.mrd.req = 1'b1; // R12
                    s_d.mrd.addr = dir_addr;
                    s_d.mrd.vidx = dir_addr[VIDX_LSB +: VIDX_W]; // R14
                    s_d.mrd.coherent = 1'b1; // R15
                    s_d.st = ST_FETCH;
                end else begin
                    s_d.rsp.hard_err = 1'b1; // R21
                    s_d.err_seen = 1'b1;
                    s_d.rsp.done = 1'b1;
                    s_d.st = ST_IDLE;
                end
            end
            ST_FETCH: begin
                if (mrd_ack) begin
                    if (fetched[VALID_BIT]) begin
                        // a command write in the same cycle blocks the port: neither it
                        // nor the fill is written, and the next lookup refetches
                        ram_we = ~reg_wr || reg_addr != OFS_CMD; // R16
                        ram_widx = look_idx;
                        ram_wdata = fetched;
                        s_d.rsp.entry = fetched;
                    end else begin
                        s_d.rsp.hard_err = 1'b1; // R20
                        s_d.err_seen = 1'b1;
                    end
                    s_d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                s_d.rsp.done = 1'b1; // R16
                s_d.st = ST_IDLE;
            end
        endcase
        if (!nrst) begin
            s_d = '0;
            s_d.mask = MASK_RST;
            s_d.mode = MODE_RST;
            s_d.st = ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    assign reg_rdata = s_q.rdata;
    assign rsp = s_q.rsp;
    assign mrd = s_q.mrd;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_bypass_io: assert property (@(posedge mclk) disable iff (!nrst) // R5
        s_q.st == ST_IDLE && req.valid && req.addr[31:28] == 4'hF
        |=> rsp.done && rsp.bypass && !mrd.req)
        else $error("io space address not bypassed");
    a_real_bypass: assert property (@(posedge mclk) disable iff (!nrst) // R5
        s_q.st == ST_IDLE && req.valid && s_q.mode == IOTLB_REAL
        |=> rsp.done && rsp.bypass)
        else $error("off mode request not bypassed");
    a_top_byte: assert property (@(posedge mclk) disable iff (!nrst) // R6
        s_q.mask == 32'hFF000000 |-> look_idx == s_q.vpn[19:12])
        else $error("top byte not used as index");
    // mask one place right: the newly taken low bit lands in the index msb
    a_shift_map: assert property (@(posedge mclk) disable iff (!nrst) // R7
        s_q.mask == 32'h7F800000
        |-> look_idx == {s_q.vpn[11], s_q.vpn[18:12]})
        else $error("shifted mask index wrong");
    a_cmd_same: assert property (@(posedge mclk) disable iff (!nrst) // R4
        reg_wdata[31:12] == s_q.vpn |-> cmd_idx == look_idx)
        else $error("command and lookup index differ");
    // tag is vpn bits 11..0 whatever the mask; compare uses the launched read
    a_hit_entry: assert property (@(posedge mclk) disable iff (!nrst) // R19
        s_q.st == ST_LOOK && ram_rd_q[VALID_BIT]
        && ram_rd_q[TAG_W:TAG_EBIT] == s_q.vpn[11:0]
        |=> rsp.done && !rsp.hard_err && rsp.entry == $past(ram_rd_q))
        else $error("hit not answered with its entry");
    a_tag_miss: assert property (@(posedge mclk) disable iff (!nrst) // R19
        s_q.st == ST_LOOK && ram_rd_q[VALID_BIT]
        && ram_rd_q[TAG_W:TAG_EBIT] != s_q.vpn[11:0]
        |=> !rsp.done || rsp.hard_err)
        else $error("tag mismatch taken as hit");
    a_miss_fetch: assert property (@(posedge mclk) disable iff (!nrst) // R12
        s_q.st == ST_LOOK && s_q.mode == IOTLB_NORMAL
        && !ram_rd_q[VALID_BIT] |=> mrd.req && mrd.coherent)
        else $error("miss did not fetch coherently");
    a_mrd_once: assert property (@(posedge mclk) disable iff (!nrst) // R12
        mrd.req |-> s_q.st == ST_FETCH ##1 !mrd.req)
        else $error("directory read not a single pulse");
    a_dir_addr: assert property (@(posedge mclk) disable iff (!nrst) // R13
        mrd.req |-> mrd.addr == s_q.base + {20'h00000, s_q.vpn}
        && mrd.vidx == mrd.addr[22:13])
        else $error("directory address wrong");
    a_soft_err: assert property (@(posedge mclk) disable iff (!nrst) // R21
        s_q.st == ST_LOOK && s_q.mode == IOTLB_ERROR
        && !ram_rd_q[VALID_BIT] |=> rsp.done && rsp.hard_err)
        else $error("software-fill miss no error");
    // a stalled lookup neither answers nor leaves the fetch state
    a_fetch_hold: assert property (@(posedge mclk) disable iff (!nrst) // R16
        s_q.st == ST_FETCH && !mrd_ack |=> s_q.st == ST_FETCH && !rsp.done)
        else $error("stalled lookup moved on");
    // fill takes the port unless a command write collides
    a_fill_write: assert property (@(posedge mclk) disable iff (!nrst) // R16
        s_q.st == ST_FETCH && mrd_ack && fetched[VALID_BIT]
        && !(reg_wr && reg_addr == OFS_CMD)
        |-> ram_we && ram_widx == look_idx && ram_wdata == fetched)
        else $error("fetched entry not written to ram");
    a_fill_done: assert property (@(posedge mclk) disable iff (!nrst) // R20
        s_q.st == ST_FETCH && mrd_ack |=> ##1 rsp.done
        && rsp.hard_err == !$past(fetched[VALID_BIT], 2))
        else $error("fill completion wrong");
    // mask in the middle: the two nibbles of the index swap places
    a_one_hot_or: assert property (@(posedge mclk) disable iff (!nrst) // R2
        s_q.mask == 32'h0FF00000
        |-> look_idx == {s_q.vpn[11:8], s_q.vpn[15:12]})
        else $error("and-or extract wrong");
    // main scenarios
    c_bypass: cover property (@(posedge mclk) rsp.done && rsp.bypass);
    c_fetch: cover property (@(posedge mclk) mrd.req ##[1:20] mrd_ack);
    c_hit: cover property (@(posedge mclk)
        rsp.done && !rsp.hard_err && !rsp.bypass);
    c_hard_err: cover property (@(posedge mclk) rsp.done && rsp.hard_err);
    c_shift_hit: cover property (@(posedge mclk)
        s_q.mask == 32'h7F800000 && rsp.done);
endmodule : iotlb_top

// eight-bit and/or field extract over the 20-bit page number
module iotlb_extract
    import iotlb_pkg::*;
(
    input wire logic [VPN_W-1:0] mask, // mask bits for page number
    input wire logic [VPN_W-1:0] vpn, // page number
    output logic [IDX_W-1:0] idx // ram index
);
    logic [23:0] m, v;
    // pad to three arrays of eight; bit k of each array feeds idx bit k
    assign m = {mask, 4'h0};
    assign v = {vpn, 4'h0};
    // consecutive mask bits let only one array drive each index bit
    // R1 R2 R3: lower array fills index msb as mask slides right
    assign idx = (m[23:16] & v[23:16]) | (m[15:8] & v[15:8])
        | (m[7:0] & v[7:0]);
endmodule : iotlb_extract

// [sim/iotlb_dir_mem.sv]
// page directory memory model answering directory reads
`timescale 1ns/10ps
module iotlb_dir_mem
    import iotlb_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic nrst, // sync reset, active low
    input wire iotlb_mrd_t mrd, // directory read request
    input wire logic [7:0] delay, // cycles before the answer
    input wire logic ent_valid, // valid bit of returned entries
    output logic mrd_ack, // data valid pulse
    output logic [4*ENT_W-1:0] mrd_data // four entries
);
    logic [4*ENT_W-1:0] line_q;
    ////////////////////////////////////////////////////////////////////////
    // table stays resident, so every read gets an answer
    initial begin
        mrd_ack = 1'b0;
        mrd_data = '0;
        forever begin
            @(posedge mclk);
            if (nrst === 1'b1 && mrd.req === 1'b1) begin
                // entry k carries k+1 on top so a wrong pick shows
                for (int k = 0; k < 4; k++) begin
                    line_q[k*ENT_W +: ENT_W] =
                        {8'(k + 1), 16'h0, mrd.addr[39:1], ent_valid};
                end
                repeat (delay) @(posedge mclk);
                mrd_ack <= 1'b1;
                mrd_data <= line_q;
                @(posedge mclk);
                mrd_ack <= 1'b0;
                // data not held after the pulse
                mrd_data <= ~line_q;
            end
        end
    end
endmodule : iotlb_dir_mem

// [sim/test_iotlb_top.sv]
// self-checking bench for the io tlb index and miss fetch block
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module test_iotlb_top
    import iotlb_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    iotlb_req_t req = '0;
    iotlb_rsp_t rsp;
    iotlb_mrd_t mrd;
    logic mrd_ack;
    logic [4*ENT_W-1:0] mrd_data;
    logic [7:0] delay = 8'h3;
    logic ent_valid = 1'b1;
    logic fetched;
    logic [39:0] exp_a;
    int errors = 0;
    int checked = 0;
    iotlb_top uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .req(req), .rsp(rsp), .mrd(mrd),
        .mrd_ack(mrd_ack), .mrd_data(mrd_data));
    iotlb_dir_mem dir (.mclk(mclk), .nrst(nrst), .mrd(mrd), .delay(delay),
        .ent_valid(ent_valid), .mrd_ack(mrd_ack), .mrd_data(mrd_data));
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        `CHK(n, e, reg_rdata)
    endtask : rd
    // entry register then load command at the page number
    task load(input logic [31:0] page, input logic [31:0] lo, hi);
        wr(OFS_ELO, lo);
        wr(OFS_EHI, hi);
        wr(OFS_CMD, page);
    endtask : load
    // bounded wait for done; a fetch pulse on the way is noted
    task look(input logic [31:0] a);
        int i;
        fetched = 1'b0;
        @(posedge mclk);
        req <= '{1'b1, a};
        @(posedge mclk);
        req.valid <= 1'b0;
        for (i = 0; i < 60; i++) begin
            #1;
            if (mrd.req === 1'b1) fetched = 1'b1;
            if (rsp.done === 1'b1) break;
            @(posedge mclk);
        end
        if (i == 60) begin
            errors++;
            report_and_stop();
        end
    endtask : look
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        rd(OFS_MASK, MASK_RST, "mask rst");
        rd(OFS_MODE, 32'(MODE_RST), "mode rst");
        rd(4'hF, 32'h0, "unmapped");
        look(32'h1234_5678);
        `CHK("real bypass", 1'b1, rsp.bypass)
        wr(OFS_MASK, 32'hFF00_0000);
        rd(OFS_MASK, 32'hFF00_0000, "mask");
        wr(OFS_MODE, 32'(IOTLB_ERROR));
        for (int j = 1; j < 4; j++) load({8'(j), 24'h0}, 32'h0, 32'h0);
        look(32'h0300_0000);
        `CHK("soft miss", 1'b1, rsp.hard_err)
        rd(OFS_STATUS, 32'h0000_0008, "err seen");
        wr(OFS_STATUS, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0000, "err clear");
        load(32'hEF00_0000, 32'h0000_0001, 32'hCAFE_0000);
        look(32'hEF00_0123);
        `CHK("entry EF", 64'hCAFE_0000_0000_0001, rsp.entry)
        `CHK("hit err", 1'b0, rsp.hard_err)
        look(32'hF000_0000);
        `CHK("io bypass", 1'b1, rsp.bypass)
        // shifted mask: 008x and 7F8x take separate entries
        wr(OFS_MASK, 32'h7F80_0000);
        load(32'h0080_0000, 32'h0000_1001, 32'h0000_0080);
        load(32'h7F80_0000, 32'h0000_1001, 32'h0000_00FF);
        look(32'h7F80_0040);
        `CHK("entry FF", 64'h0000_00FF_0000_1001, rsp.entry)
        look(32'h0080_0000);
        `CHK("entry 80", 64'h0000_0080_0000_1001, rsp.entry)
        // same index, other tag: must not be taken as a hit
        look(32'h7F80_1000);
        `CHK("tag miss", 1'b1, rsp.hard_err)
        // mask in the middle of the page number
        wr(OFS_MASK, 32'h0FF0_0000);
        load(32'h0AB0_0000, 32'h0000_1601, 32'h0000_00BA);
        look(32'h0AB0_0123);
        `CHK("entry BA", 64'h0000_00BA_0000_1601, rsp.entry)
        // auto fill from the directory
        wr(OFS_MASK, 32'hFF00_0000);
        wr(OFS_BASE_HI, 32'h0000_0012);
        wr(OFS_BASE_LO, 32'h0000_1000);
        wr(OFS_MODE, 32'(IOTLB_NORMAL));
        exp_a = 40'h12_0000_1000 + 40'h01236;
        look(32'h0123_6567);
        `CHK("fetch", 1'b1, fetched)
        `CHK("dir addr", exp_a, mrd.addr)
        `CHK("vidx", exp_a[22:13], mrd.vidx)
        `CHK("coherent", 1'b1, mrd.coherent)
        `CHK("fill entry", {8'h03, 16'h0, exp_a[39:1], 1'b1}, rsp.entry)
        `CHK("fill err", 1'b0, rsp.hard_err)
        ent_valid <= 1'b0;
        delay <= 8'h0;
        look(32'h0223_4567);
        `CHK("invalid fill", 1'b1, rsp.hard_err)
        report_and_stop();
    end
endmodule : test_iotlb_top
